// file: rtl/pin_override_cell.sv
`timescale 1ns/10ps
`default_nettype none
// one pad: applies the generic override equations
module pin_override_cell (
    input  wire logic i_dir_bit,
    input  wire logic i_latch_bit,
    input  wire logic i_pull_dis,
    input  wire logic i_sleep,
    input  wire logic i_pullup_override_enable,
    input  wire logic i_pullup_override_value,
    input  wire logic i_direction_override_enable,
    input  wire logic i_direction_override_value,
    input  wire logic i_port_value_override_enable,
    input  wire logic i_port_value_override_value,
    input  wire logic i_input_enable_override_enable,
    input  wire logic i_input_enable_override_value,
    output logic      o_pullup,
    output logic      o_drive_en,
    output logic      o_drive_val,
    output logic      o_input_en
);
    // pull-up: override, else only {dir,latch,disable} = 0b010
    assign o_pullup    = i_pullup_override_enable ? i_pullup_override_value
                       : ({i_dir_bit, i_latch_bit, i_pull_dis}
                          == port_ab_mux_pkg::PULLUP_PATTERN);
    assign o_drive_en  = i_direction_override_enable ? i_direction_override_value : i_dir_bit;
    assign o_drive_val = (i_port_value_override_enable && o_drive_en) ? i_port_value_override_value : i_latch_bit;
    assign o_input_en  = i_input_enable_override_enable ? i_input_enable_override_value : ~i_sleep;
endmodule
`default_nettype wire

// file: rtl/port_ab_alt_mux.sv
`timescale 1ns/10ps
`default_nettype none
// alternate-function override logic for port a (lcd) and port b (timers, spi, pin change)
// every pad-control output is combinational from the control bits, so a change in
// lcd, timer or spi setup reaches the pin in the same cycle
// each pin runs through one override cell; this file builds the override vectors and the port b pad synchroniser
// port a hands pins 7..4 to lcd segments 3..0 and pins 3..0 to commons 3..0
// commons above the duty select stay ordinary port pins
// port b pins 7..4 carry timer compare/pwm waves when their direction bit and their compare output enable are set
// port b pins 3..0 follow the spi role: forced inputs keep their latch pull-up,
// but the global pull-up disable still wins over that latch
// port b pad levels pass three flops; a pin change bit moves only when the
// last two stages agree, so the new level shows four edges after the pad moves
// the port a pad levels are not used here: lcd lines are analog
module port_ab_alt_mux (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,

    // global control
    input  wire logic [7:0] i_mcu_control_register,
    input  wire logic       i_sleep,

    // port a register bits and pads
    input  wire logic [7:0] i_porta_direction,
    input  wire logic [7:0] i_porta_latch,
    input  wire logic [7:0] i_porta_pad,

    // lcd controller setup
    input  wire logic       i_lcd_enable,
    input  wire logic [1:0] i_lcd_duty_select,

    // port b register bits and pads
    input  wire logic [7:0] i_portb_direction,
    input  wire logic [7:0] i_portb_latch,
    input  wire logic [7:0] i_portb_pad,

    // timer compare waves and their output enables
    input  wire logic       i_timer2_compare_a_out,
    input  wire logic       i_timer2_compare_a_en,
    input  wire logic       i_timer1_compare_b_out,
    input  wire logic       i_timer1_compare_b_en,
    input  wire logic       i_timer1_compare_a_out,
    input  wire logic       i_timer1_compare_a_en,
    input  wire logic       i_timer0_compare_a_out,
    input  wire logic       i_timer0_compare_a_en,

    // pin change source enables
    input  wire logic [7:0] i_pin_change_mask,
    input  wire logic       i_pin_change_group_en,

    // spi role and spi core outputs
    input  wire logic       i_spi_enable,
    input  wire logic       i_spi_master,
    input  wire logic       i_spi_slave_out,
    input  wire logic       i_spi_master_out,
    input  wire logic       i_spi_sck_out,

    // port a pad control
    output logic [7:0]      o_porta_pullup,
    output logic [7:0]      o_porta_drive_en,
    output logic [7:0]      o_porta_drive_val,
    output logic [7:0]      o_porta_input_en,

    // lcd line routing
    output logic [3:0]      o_lcd_segment_line_en,
    output logic [3:0]      o_lcd_common_line_en,

    // port b pad control
    output logic [7:0]      o_portb_pullup,
    output logic [7:0]      o_portb_drive_en,
    output logic [7:0]      o_portb_drive_val,
    output logic [7:0]      o_portb_input_en,

    // settled pin levels for the pin change logic
    output logic [7:0]      o_pin_change_source,

    // settled pin levels for the spi core
    output logic            o_spi_miso_in,
    output logic            o_spi_mosi_in,
    output logic            o_spi_sck_in,
    output logic            o_spi_ss_in
);
    // global pull-up disable and spi role decode
    logic       pullup_global_disable;
    logic       spi_master_on;
    logic       spi_slave_on;

    // port a: one lcd ownership bit and the parked override values per pin
    logic [7:0] a_ovr_en;
    logic [7:0] a_pullup_override_value;
    logic [7:0] a_direction_override_value;
    logic [7:0] a_port_value_override_enable;
    logic [7:0] a_port_value_override_value;
    logic [7:0] a_input_enable_override_value;

    // port b: full override set per pin
    logic [7:0] b_pullup_override_enable;
    logic [7:0] b_pullup_override_value;
    logic [7:0] b_direction_override_enable;
    logic [7:0] b_direction_override_value;
    logic [7:0] b_port_value_override_enable;
    logic [7:0] b_port_value_override_value;
    logic [7:0] b_input_enable_override_enable;
    logic [7:0] b_input_enable_override_value;

    // timer compare channels, index 3..0 = pins 7..4
    logic [3:0] cmp_en;
    logic [3:0] cmp_out;

    // spi pin group, index 3..0 = pins 3..0
    logic [3:0] spi_pullup_override_enable;
    logic [3:0] spi_pullup_override_value;
    logic [3:0] spi_direction_override_enable;
    logic [3:0] spi_port_value_override_enable;
    logic [3:0] spi_port_value_override_value;

    // pad synchroniser stages and settled levels
    logic [7:0] portb_sync1_ff;
    logic [7:0] portb_sync2_ff;
    logic [7:0] portb_sync3_ff;
    logic [7:0] pin_change_ff;
    logic [7:0] nxt_pin_change;

    // global disable bit, shared by every pin of both ports
    assign pullup_global_disable =
        i_mcu_control_register[port_ab_mux_pkg::MCU_PULL_DIS_BIT];

    // port a: lcd ownership per pin, all combinational
    assign a_ovr_en[7:4] = {4{i_lcd_enable}};
    assign a_ovr_en[3]   = i_lcd_enable && (i_lcd_duty_select > port_ab_mux_pkg::DUTY_COM3_MIN);
    assign a_ovr_en[2]   = i_lcd_enable && (i_lcd_duty_select > port_ab_mux_pkg::DUTY_COM2_MIN);
    assign a_ovr_en[1]   = i_lcd_enable && (i_lcd_duty_select > port_ab_mux_pkg::DUTY_COM1_MIN);
    assign a_ovr_en[0]   = i_lcd_enable;

    // port a override values: every lcd pin is parked with all values at zero
    assign a_pullup_override_value  = 8'h00;
    assign a_direction_override_value  = 8'h00;
    assign a_port_value_override_enable  = 8'h00;
    assign a_port_value_override_value  = 8'h00;
    assign a_input_enable_override_value = 8'h00;

    // pad routing to the lcd analog lines: segment 3..0 on pins 7..4, common 3..0 on 3..0
    assign o_lcd_segment_line_en = a_ovr_en[7:4];
    assign o_lcd_common_line_en  = a_ovr_en[3:0];

    // spi mode decode
    assign spi_master_on = i_spi_enable && i_spi_master;
    assign spi_slave_on  = i_spi_enable && !i_spi_master;

    // timer compare waves; the pad only shows them while its driver is on
    assign cmp_en  = {i_timer2_compare_a_en, i_timer1_compare_b_en,
                      i_timer1_compare_a_en, i_timer0_compare_a_en};
    assign cmp_out = {i_timer2_compare_a_out, i_timer1_compare_b_out,
                      i_timer1_compare_a_out, i_timer0_compare_a_out};

    // spi pin group: each pin's role depends on master or slave mode
    always_comb begin
        spi_pullup_override_enable = 4'h0;
        spi_pullup_override_value = 4'h0;
        spi_direction_override_enable = 4'h0;
        spi_port_value_override_enable = 4'h0;
        spi_port_value_override_value = 4'h0;

        // miso: input when master, own direction bit when slave
        spi_pullup_override_enable[3] = spi_master_on;
        spi_direction_override_enable[3] = spi_master_on;
        spi_pullup_override_value[3] = i_portb_latch[3] && !pullup_global_disable;
        spi_port_value_override_enable[3] = spi_slave_on;
        spi_port_value_override_value[3] = i_spi_slave_out;

        // mosi: input when slave, own direction bit when master
        spi_pullup_override_enable[2] = spi_slave_on;
        spi_direction_override_enable[2] = spi_slave_on;
        spi_pullup_override_value[2] = i_portb_latch[2] && !pullup_global_disable;
        spi_port_value_override_enable[2] = spi_master_on;
        spi_port_value_override_value[2] = i_spi_master_out;

        // sck: input when slave, own direction bit when master
        spi_pullup_override_enable[1] = spi_slave_on;
        spi_direction_override_enable[1] = spi_slave_on;
        spi_pullup_override_value[1] = i_portb_latch[1] && !pullup_global_disable;
        spi_port_value_override_enable[1] = spi_master_on;
        spi_port_value_override_value[1] = i_spi_sck_out;

        // slave select: input when slave, never driven by the spi core
        spi_pullup_override_enable[0] = spi_slave_on;
        spi_direction_override_enable[0] = spi_slave_on;
        spi_pullup_override_value[0] = i_portb_latch[0] && !pullup_global_disable;
    end

    // port b: pins 7..4 timer outputs, pins 3..0 spi group
    assign b_pullup_override_enable  = {4'h0, spi_pullup_override_enable};
    assign b_pullup_override_value  = {4'h0, spi_pullup_override_value};
    assign b_direction_override_enable  = {4'h0, spi_direction_override_enable};
    assign b_direction_override_value  = 8'h00; // forced inputs never drive
    assign b_port_value_override_enable  = {cmp_en, spi_port_value_override_enable};
    assign b_port_value_override_value  = {cmp_out, spi_port_value_override_value};
    assign b_input_enable_override_value = 8'hff; // pin change sources keep the buffer on

    // pin change sources keep the input buffer awake in sleep
    assign b_input_enable_override_enable = i_pin_change_mask & {8{i_pin_change_group_en}};

    // per-pin override cells for both ports
    genvar g;
    generate
        for (g = 0; g < port_ab_mux_pkg::PORT_WIDTH; g++) begin : gen_pin
            // port a pin: plain port unless the lcd owns it
            pin_override_cell u_a (
                .i_dir_bit   (i_porta_direction[g]),
                .i_latch_bit (i_porta_latch[g]),
                .i_pull_dis  (pullup_global_disable),
                .i_sleep     (i_sleep),
                .i_pullup_override_enable      (a_ovr_en[g]),
                .i_pullup_override_value      (a_pullup_override_value[g]),
                .i_direction_override_enable      (a_ovr_en[g]),
                .i_direction_override_value      (a_direction_override_value[g]),
                .i_port_value_override_enable      (a_port_value_override_enable[g]),
                .i_port_value_override_value      (a_port_value_override_value[g]),
                .i_input_enable_override_enable     (a_ovr_en[g]),
                .i_input_enable_override_value     (a_input_enable_override_value[g]),
                .o_pullup    (o_porta_pullup[g]),
                .o_drive_en  (o_porta_drive_en[g]),
                .o_drive_val (o_porta_drive_val[g]),
                .o_input_en  (o_porta_input_en[g])
            );
            // port b pin: timer or spi overrides, pin change keeps the input awake
            pin_override_cell u_b (
                .i_dir_bit   (i_portb_direction[g]),
                .i_latch_bit (i_portb_latch[g]),
                .i_pull_dis  (pullup_global_disable),
                .i_sleep     (i_sleep),
                .i_pullup_override_enable      (b_pullup_override_enable[g]),
                .i_pullup_override_value      (b_pullup_override_value[g]),
                .i_direction_override_enable      (b_direction_override_enable[g]),
                .i_direction_override_value      (b_direction_override_value[g]),
                .i_port_value_override_enable      (b_port_value_override_enable[g]),
                .i_port_value_override_value      (b_port_value_override_value[g]),
                .i_input_enable_override_enable     (b_input_enable_override_enable[g]),
                .i_input_enable_override_value     (b_input_enable_override_value[g]),
                .o_pullup    (o_portb_pullup[g]),
                .o_drive_en  (o_portb_drive_en[g]),
                .o_drive_val (o_portb_drive_val[g]),
                .o_input_en  (o_portb_input_en[g])
            );
        end
    endgenerate

    // three-stage pad synchroniser; a change counts once stages two and three agree
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            portb_sync1_ff <= port_ab_mux_pkg::PORT_RESET_VALUE;
            portb_sync2_ff <= port_ab_mux_pkg::PORT_RESET_VALUE;
            portb_sync3_ff <= port_ab_mux_pkg::PORT_RESET_VALUE;
        end else begin
            portb_sync1_ff <= i_portb_pad & o_portb_input_en;
            portb_sync2_ff <= portb_sync1_ff;
            portb_sync3_ff <= portb_sync2_ff;
        end
    end

    // settled level: a bit moves only where stages two and three agree,
    // so a pad caught mid-transition never flickers the pin change source
    generate
        for (g = 0; g < port_ab_mux_pkg::PORT_WIDTH; g++) begin : gen_settle
            assign nxt_pin_change[g] = (portb_sync2_ff[g] == portb_sync3_ff[g])
                                     ? portb_sync2_ff[g] : pin_change_ff[g];
        end
    endgenerate

    // pin level to pin change sources 15..8
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pin_change_ff <= port_ab_mux_pkg::PORT_RESET_VALUE;
        end else begin
            pin_change_ff <= nxt_pin_change;
        end
    end

    assign o_pin_change_source = pin_change_ff;
    assign o_spi_miso_in       = pin_change_ff[port_ab_mux_pkg::SPI_MISO_PIN];
    assign o_spi_mosi_in       = pin_change_ff[port_ab_mux_pkg::SPI_MOSI_PIN];
    assign o_spi_sck_in        = pin_change_ff[port_ab_mux_pkg::SPI_SCK_PIN];
    assign o_spi_ss_in         = pin_change_ff[port_ab_mux_pkg::SPI_SS_PIN];
endmodule
`default_nettype wire

// file: rtl/port_ab_mux_pkg.sv
// How it works
// - global pull-up disable kills every pull-up
// - port a: high nibble segments, low commons
// - segment pins overridden to zero when enabled
// - common pins 3..1 gated by lcd duty select
// - port b 7..4 carry timer compare outputs
// - compare pins also carry pwm waveforms
// - port b pins feed pin change sources 15..8
// - spi master forces miso to input
// - spi slave leaves miso direction to bit
// - spi slave forces mosi to input
// - spi slave forces sck to input
// - forced spi input keeps latch pull-up control
// - pull-up follows override or 0b010 pattern
// - driver follows direction override or bit
// - pad value follows port value override only while driven
// - input enable follows override or sleep clamp
package port_ab_mux_pkg;
    localparam int unsigned PORT_WIDTH       = 8;
    localparam int unsigned SEG_FIRST_PIN    = 4;
    localparam int unsigned SPI_MISO_PIN     = 3;
    localparam int unsigned SPI_MOSI_PIN     = 2;
    localparam int unsigned SPI_SCK_PIN      = 1;
    localparam int unsigned SPI_SS_PIN       = 0;
    localparam int unsigned MCU_PULL_DIS_BIT = 4;
    localparam int unsigned PCINT_FIRST      = 8;
    localparam int unsigned SYNC_STAGES      = 3;
    localparam logic [2:0]  PULLUP_PATTERN   = 3'h2;
    localparam logic [1:0]  DUTY_COM1_MIN    = 2'h0;
    localparam logic [1:0]  DUTY_COM2_MIN    = 2'h1;
    localparam logic [1:0]  DUTY_COM3_MIN    = 2'h2;
    localparam logic [7:0]  PORT_RESET_VALUE = 8'h00;
endpackage

// file: verification/periph_side_model.sv
`timescale 1ns/10ps
`default_nettype none
// on-chip timers and spi core as seen from the pin mux
module periph_side_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_run,
    output logic      [3:0] o_cmp_out,
    output logic      [3:0] o_cmp_en,
    output logic      [2:0] o_spi_out
);
    logic [3:0] cnt_ff;
    // free-running count gives each channel its own pwm rate
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
    // compare waveforms, their enables, then slave out, master out, sck
    assign o_cmp_out = cnt_ff;
    assign o_cmp_en  = {4{i_run}};
    assign o_spi_out = {cnt_ff[1], ~cnt_ff[1], cnt_ff[0]};
endmodule
`default_nettype wire

// file: verification/port_ab_alt_mux_checker.sv
`timescale 1ns/10ps
`default_nettype none
// pad-control relations watched at the top module's ports
module port_ab_alt_mux_checker (
    input wire logic       i_clk_sys, i_rst, i_lcd_enable, i_spi_enable, i_spi_master,
    input wire logic       i_timer2_compare_a_out, i_timer2_compare_a_en,
    input wire logic [1:0] i_lcd_duty_select,
    input wire logic [3:0] o_lcd_segment_line_en, o_lcd_common_line_en,
    input wire logic [7:0] i_mcu_control_register, i_porta_direction, i_porta_latch,
    input wire logic [7:0] i_portb_direction, i_portb_latch, i_portb_pad, o_porta_pullup,
    input wire logic [7:0] o_porta_drive_en, o_porta_input_en, o_portb_pullup, o_portb_input_en,
    input wire logic [7:0] o_portb_drive_en, o_portb_drive_val, o_pin_change_source
);
    // spi roles and the global pull-up disable bit
    wire logic pull_dis = i_mcu_control_register[4];
    wire logic mst = i_spi_enable && i_spi_master;
    wire logic slv = i_spi_enable && !i_spi_master;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // pad 0 held high and enabled long enough to clear the synchroniser
    sequence s_pad0_high;
        (i_portb_pad[0] && o_portb_input_en[0]) [*6];
    endsequence
    a_pullup_all_off: assert property (pull_dis |-> o_porta_pullup == 0 && o_portb_pullup == 0)
        else $error("pull-up on under global disable");
    a_seg_lcd_owned: assert property (i_lcd_enable |-> o_lcd_segment_line_en == 4'hf
        && (o_porta_drive_en[7:4] | o_porta_pullup[7:4] | o_porta_input_en[7:4]) == 4'h0)
        else $error("segment pins not handed to lcd");
    a_com_duty_gate: assert property (o_lcd_common_line_en == {i_lcd_enable &&
        i_lcd_duty_select > 2'h2, i_lcd_enable && i_lcd_duty_select > 2'h1,
        i_lcd_enable && i_lcd_duty_select > 2'h0, i_lcd_enable})
        else $error("common line gating wrong");
    a_plain_pullup: assert property (!i_lcd_enable |->
        o_porta_pullup == (~i_porta_direction & i_porta_latch & {8{!pull_dis}}))
        else $error("port a pull-up pattern wrong");
    a_timer_pin_out: assert property (i_portb_direction[7] |-> o_portb_drive_en[7] &&
        o_portb_drive_val[7] == (i_timer2_compare_a_en ? i_timer2_compare_a_out : i_portb_latch[7]))
        else $error("compare output not on pin 7");
    a_miso_master_in: assert property (mst |-> !o_portb_drive_en[3] &&
        o_portb_pullup[3] == (i_portb_latch[3] && !pull_dis))
        else $error("miso not input as master");
    a_miso_slave_dir: assert property (slv |-> o_portb_drive_en[3] == i_portb_direction[3])
        else $error("miso direction overridden as slave");
    a_slave_inputs: assert property (slv |-> o_portb_drive_en[2:0] == 3'h0 &&
        o_portb_pullup[2:0] == (i_portb_latch[2:0] & {3{!pull_dis}}))
        else $error("mosi or sck not input as slave");
    a_pin_change_sync: assert property (s_pad0_high |=> o_pin_change_source[0])
        else $error("pin change source missed a high pad");
endmodule
bind port_ab_alt_mux port_ab_alt_mux_checker u_chk (.*);
`default_nettype wire

// file: verification/port_ab_alt_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module port_ab_alt_mux_tb;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, i_sleep = 1'b0, i_lcd_enable = 1'b0, run = 1'b0;
    logic i_spi_enable = 1'b0, i_spi_master = 1'b0, i_pin_change_group_en = 1'b0;
    logic [1:0] i_lcd_duty_select = 2'h0;
    logic [7:0] i_mcu_control_register = 8'h00, i_porta_direction = 8'h00, i_porta_latch = 8'h00;
    logic [7:0] i_porta_pad = 8'h00, i_portb_direction = 8'h00, i_portb_latch = 8'h00;
    logic [7:0] i_portb_pad = 8'h00, i_pin_change_mask = 8'h00, o_pin_change_source;
    wire logic i_timer2_compare_a_out, i_timer2_compare_a_en, i_timer1_compare_b_out;
    wire logic i_timer1_compare_b_en, i_timer1_compare_a_out, i_timer1_compare_a_en;
    wire logic i_timer0_compare_a_out, i_timer0_compare_a_en;
    wire logic i_spi_slave_out, i_spi_master_out, i_spi_sck_out;
    logic [7:0] o_porta_pullup, o_porta_drive_en, o_porta_drive_val, o_porta_input_en;
    logic [7:0] o_portb_pullup, o_portb_drive_en, o_portb_drive_val, o_portb_input_en;
    logic [3:0] o_lcd_segment_line_en, o_lcd_common_line_en;
    logic o_spi_miso_in, o_spi_mosi_in, o_spi_sck_in, o_spi_ss_in;
    int n_errors = 0, compares = 0;
    // lcd enable, duty, expected commons, expected port a drivers (directions all out)
    logic [14:0] rows [5] = '{{1'b1, 2'h0, 4'h1, 8'h0e}, {1'b1, 2'h1, 4'h3, 8'h0c},
        {1'b1, 2'h2, 4'h7, 8'h08}, {1'b1, 2'h3, 4'hf, 8'h00}, {1'b0, 2'h3, 4'h0, 8'hff}};
    port_ab_alt_mux dut (.*);
    periph_side_model partner (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_run(run),
        .o_cmp_out({i_timer2_compare_a_out, i_timer1_compare_b_out, i_timer1_compare_a_out,
            i_timer0_compare_a_out}),
        .o_cmp_en({i_timer2_compare_a_en, i_timer1_compare_b_en, i_timer1_compare_a_en,
            i_timer0_compare_a_en}),
        .o_spi_out({i_spi_slave_out, i_spi_master_out, i_spi_sck_out}));
    always #10 i_clk_sys = ~i_clk_sys;
    task automatic test_done;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog well beyond the few dozen cycles the tests need
    initial begin
        #20000;
        n_errors++;
        test_done;
    end
    // reset, table sweep, then hand-written cases
    initial begin
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        `CHK("rst_src", 8'h00, o_pin_change_source)
        $display("reset done");
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        i_porta_direction <= 8'hff;
        for (int k = 0; k < 5; k++) begin
            @(posedge i_clk_sys);
            {i_lcd_enable, i_lcd_duty_select} <= rows[k][14:12];
            @(negedge i_clk_sys);
            `CHK("com_en", rows[k][11:8], o_lcd_common_line_en)
            `CHK("pa_drv", rows[k][7:0], o_porta_drive_en)
        end
        $display("lcd table done");
        @(posedge i_clk_sys);
        {i_porta_direction, i_porta_latch} <= 16'h0fff;
        @(negedge i_clk_sys);
        `CHK("pa_pu", 8'hf0, o_porta_pullup)
        `CHK("pa_val", 8'hff, o_porta_drive_val)
        @(posedge i_clk_sys);
        i_mcu_control_register <= 8'h10;
        @(negedge i_clk_sys);
        `CHK("pa_pud", 8'h00, o_porta_pullup)
        $display("pull-up done");
        @(posedge i_clk_sys);
        {i_mcu_control_register, i_portb_direction, i_portb_latch} <= 24'h00_0f0f;
        {i_spi_enable, i_spi_master} <= 2'h3;
        @(negedge i_clk_sys);
        `CHK("pb_drv_m", 8'h07, o_portb_drive_en)
        `CHK("pb_pu_m", 8'h08, o_portb_pullup)
        `CHK("mosi_val", i_spi_master_out, o_portb_drive_val[2])
        @(posedge i_clk_sys);
        i_spi_master <= 1'b0;
        @(negedge i_clk_sys);
        `CHK("pb_drv_s", 8'h08, o_portb_drive_en)
        `CHK("pb_pu_s", 8'h07, o_portb_pullup)
        `CHK("miso_val", i_spi_slave_out, o_portb_drive_val[3])
        $display("spi done");
        @(posedge i_clk_sys);
        {i_spi_enable, run, i_portb_direction, i_portb_latch} <= 18'h1_f000;
        repeat (4) begin
            @(negedge i_clk_sys);
            `CHK("cmp", {i_timer2_compare_a_out, i_timer1_compare_b_out, i_timer1_compare_a_out,
                i_timer0_compare_a_out}, o_portb_drive_val[7:4])
        end
        @(posedge i_clk_sys);
        {run, i_portb_latch} <= 9'h050;
        @(negedge i_clk_sys);
        `CHK("cmp_off", 4'h5, o_portb_drive_val[7:4])
        $display("timer done");
        @(posedge i_clk_sys);
        {i_sleep, i_pin_change_group_en, i_pin_change_mask, i_portb_pad} <= 18'h3_ffa5;
        @(negedge i_clk_sys);
        `CHK("pb_ie", 8'hff, o_portb_input_en)
        `CHK("pa_ie", 8'h00, o_porta_input_en)
        repeat (6) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        `CHK("src", 8'ha5, o_pin_change_source)
        `CHK("spi_in", 4'h5, {o_spi_miso_in, o_spi_mosi_in, o_spi_sck_in, o_spi_ss_in})
        $display("pin change done");
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        @(negedge i_clk_sys);
        `CHK("rst_mid", 8'h00, o_pin_change_source)
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        `CHK("rst_back", 8'ha5, o_pin_change_source)
        $display("mid-run reset done");
        test_done;
    end
endmodule
`default_nettype wire
